// ### include/smcg_pkg.sv
// package for the sleep-mode and clock-gating controller
// assumes a single 20 MHz system clock domain
package smcg_pkg;
  // ==========================================
  // sleep select codes
  localparam logic [2:0] SEL_IDLE     = 3'h0;
  localparam logic [2:0] SEL_ADCNR    = 3'h1;
  localparam logic [2:0] SEL_PDOWN    = 3'h2;
  localparam logic [2:0] SEL_PSAVE    = 3'h3;
  localparam logic [2:0] SEL_STBY     = 3'h6;
  localparam logic [2:0] SEL_XSTBY    = 3'h7;
  // ==========================================
  // core control register field positions
  localparam int CCR_OFF_BIT    = 6;
  localparam int CCR_UNLOCK_BIT = 5;
  localparam logic CCR_OFF_RESET = 1'b0;
  // ==========================================
  // timing
  localparam int CLK_HZ          = 20_000_000;
  localparam int CLK_PERIOD_NS   = 50;
  localparam int UNLOCK_WINDOW   = 4;
  localparam int OFF_ACT_DELAY   = 3;
  localparam int OFF_HOLD        = 3;
  localparam int IRQ_HALT        = 4;
  localparam int XTAL_WAKE       = 6;
  localparam int MON_WAKE_US     = 60;
  localparam int MON_WAKE_CYC    = (MON_WAKE_US * 1000) / CLK_PERIOD_NS;
  localparam int STARTUP_DEFAULT = 16;
  // ==========================================
  // peripheral gate vector positions
  localparam int PG_ADC = 0;
  localparam int PG_TIMER_SYNC = 6;
  localparam int PG_WIDTH = 8;
endpackage

// ### logic/smcg_ctrl.sv
// sleep-mode and clock-gating controller: mode select, supply monitor
// sleep-off sequence, wake filtering, wake delays and peripheral clock gates.
// assumes the core pulses sleep_instr for one clock and wake sources are synchronous.
//
// Notes on behaviour
// - monitor switched off immediately on entry to codes 010, 011, 110 or 111 when sleep-off bit active
// - monitor re-enabled automatically on any wake-up
// - wake delayed about 60 us when monitor was off during sleep
// - sleep-off control is bit 6 of core control, resets to zero
// - sleep-off bit changes only through timed unlock sequence
// - sleep-off bit active three cycles after set, clears after three more
// - sleep entered only with arm bit set and sleep instruction
// - interrupt wake halts core four cycles beyond start-up
// - code 000 Idle stops core and program store clocks only
// - converter enabled entering Idle or ADC noise sleep starts conversion
// - code 001 also halts peripheral io clock
// - ADC noise sleep wakes only on its listed sources
// - code 010 Power-down stops oscillator and all generated clocks
// - Power-down wakes only on resets, address match, low lines, pin change
// - Power-down wake waits fuse-defined start-up delay
// - code 011 Power-save keeps async timer, its enabled irqs wake
// - Power-save stops unused timer oscillator, and main clock unless the timer runs synchronously
// - code 110 with crystal Standby keeps oscillator, wakes in six cycles
// - code 111 with crystal Extended Standby, wakes in six cycles
// - gate bit stops peripheral clock, except the synchronous timer clock in codes 011 and 111
// - clearing gate bit restarts clock with state kept
// - gating matters only in Active and Idle, and for the ADC gate in ADC noise sleep
// - converter stays enabled in sleep; off-on gives extended conversion
module smcg_ctrl #(
  parameter int STARTUP_CYC = smcg_pkg::STARTUP_DEFAULT,
  parameter int MON_CYC     = smcg_pkg::MON_WAKE_CYC
) (
  input  wire logic                        clock,
  input  wire logic                        resetn,
  input  wire logic                        clk_en,
  input  wire logic                        ccr_wr,
  input  wire logic [7:0]                  ccr_wdata,
  input  wire logic                        sleep_arm_bit,
  input  wire logic [2:0]                  sleep_select_code,
  input  wire logic                        sleep_instr,
  input  wire logic                        xtal_selected,
  input  wire logic                        monitor_fuse_on,
  input  wire logic                        adc_enable,
  input  wire logic                        timer_async,
  input  wire logic                        timer_enable,
  input  wire logic [1:0]                  async_timer_irq_mask,
  input  wire logic                        global_irq_en,
  input  wire logic [1:0]                  async_timer_events,
  input  wire logic                        ext_reset_wake,
  input  wire logic                        wdt_reset_wake,
  input  wire logic                        wdt_irq_wake,
  input  wire logic                        mon_reset_wake,
  input  wire logic                        twi_addr_match,
  input  wire logic                        twi_irq,
  input  wire logic [2:0]                  low_ext_irq_lines,
  input  wire logic [3:0]                  high_ext_irq_lines,
  input  wire logic                        pin_change_irq,
  input  wire logic                        adc_done_irq,
  input  wire logic                        store_ready_irq,
  input  wire logic                        other_irq,
  input  wire logic [smcg_pkg::PG_WIDTH-1:0] peripheral_clock_gate_reg,
  output logic                             core_clock_en,
  output logic                             program_store_clock_en,
  output logic                             peripheral_io_clock_en,
  output logic                             adc_clock_en,
  output logic                             main_osc_en,
  output logic                             timer_osc_en,
  output logic [smcg_pkg::PG_WIDTH-1:0]    periph_clk_en,
  output logic                             supply_drop_monitor_en,
  output logic                             monitor_sleep_off,
  output logic                             adc_start,
  output logic                             adc_extended,
  output logic                             asleep,
  output logic                             irq_resume
);
  // ==========================================
  // states
  typedef enum logic [2:0] {
    ST_RUN   = 3'b001,
    ST_SLEEP = 3'b010,
    ST_WAKE  = 3'b100
  } smcg_state_type;

  function automatic logic stops_io(input logic [2:0] m);
    stops_io = (m != smcg_pkg::SEL_IDLE);
  endfunction

  function automatic logic deep_mode(input logic [2:0] m);
    deep_mode = (m == smcg_pkg::SEL_PDOWN) || (m == smcg_pkg::SEL_PSAVE) ||
                (m == smcg_pkg::SEL_STBY) || (m == smcg_pkg::SEL_XSTBY);
  endfunction

  function automatic logic timer_mode(input logic [2:0] m);
    timer_mode = (m == smcg_pkg::SEL_PSAVE) || (m == smcg_pkg::SEL_XSTBY);
  endfunction

  smcg_state_type             state_r, state_nxt;
  logic [2:0]                 mode_r, mode_nxt;
  logic                       mon_off_r, mon_off_nxt;
  logic                       irq_wake_r, irq_wake_nxt;
  logic [15:0]                cnt_r, cnt_nxt;
  logic [2:0]                 unl_r, unl_nxt;
  logic [2:0]                 offcnt_r, offcnt_nxt;
  logic                       off_bit_r, off_bit_nxt;
  logic                       adc_en_d_r, adc_ext_r, adc_ext_nxt;
  logic                       start_r, start_nxt;
  logic                       sleep_req, valid_code, wake_irq, wake_rst, wake;
  logic [2:0]                 ce_nxt;
  logic                       osc_nxt, tosc_nxt, io_nxt, adcclk_nxt;
  logic [smcg_pkg::PG_WIDTH-1:0] pg_nxt;

  // ==========================================
  // monitor sleep-off unlock sequence
  always_comb begin
    unl_nxt     = (unl_r != 3'h0) ? unl_r - 3'h1 : 3'h0;
    offcnt_nxt  = (offcnt_r != 3'h0) ? offcnt_r - 3'h1 : 3'h0;
    off_bit_nxt = off_bit_r;
    if (offcnt_r == 3'h1) begin
      off_bit_nxt = smcg_pkg::CCR_OFF_RESET;
    end
    // rewriting during the window does not extend it
    if (ccr_wr && ccr_wdata[smcg_pkg::CCR_OFF_BIT] && ccr_wdata[smcg_pkg::CCR_UNLOCK_BIT] &&
        unl_r == 3'h0) begin
      unl_nxt = 3'(smcg_pkg::UNLOCK_WINDOW);
    end else if (ccr_wr && unl_r != 3'h0 && ccr_wdata[smcg_pkg::CCR_OFF_BIT] &&
                 !ccr_wdata[smcg_pkg::CCR_UNLOCK_BIT]) begin
      unl_nxt    = 3'h0;
      offcnt_nxt = 3'(smcg_pkg::OFF_ACT_DELAY + smcg_pkg::OFF_HOLD);
    end
    if (offcnt_r == 3'(smcg_pkg::OFF_HOLD + 1)) begin
      off_bit_nxt = 1'b1;
    end
  end

  // ==========================================
  // sleep sequencing
  assign valid_code = (sleep_select_code[2:1] != 2'b10) &&
                      (!sleep_select_code[2] || xtal_selected);
  assign sleep_req  = sleep_arm_bit && sleep_instr && valid_code;

  always_comb begin
    logic [2:0] m;
    m = mode_r;
    wake_rst = ext_reset_wake | wdt_reset_wake | mon_reset_wake;
    wake_irq = 1'b0;
    case (m)
      smcg_pkg::SEL_IDLE:  wake_irq = |{wdt_irq_wake, twi_addr_match, twi_irq, low_ext_irq_lines,
                                        high_ext_irq_lines, pin_change_irq, adc_done_irq,
                                        store_ready_irq, other_irq, async_timer_events};
      smcg_pkg::SEL_ADCNR: wake_irq = |{adc_done_irq, wdt_irq_wake, twi_irq, twi_addr_match,
                                        (timer_enable && |async_timer_events), store_ready_irq,
                                        high_ext_irq_lines, pin_change_irq};
      default: begin
        wake_irq = twi_addr_match | (|low_ext_irq_lines) | pin_change_irq;
        if (timer_mode(m)) begin
          wake_irq = wake_irq | (timer_enable && global_irq_en &&
                                 |(async_timer_events & async_timer_irq_mask));
        end
      end
    endcase
    wake = wake_rst | wake_irq;
  end

  always_comb begin
    state_nxt    = state_r;
    mode_nxt     = mode_r;
    mon_off_nxt  = mon_off_r;
    irq_wake_nxt = irq_wake_r;
    cnt_nxt      = (cnt_r != 16'h0000) ? cnt_r - 16'h0001 : 16'h0000;
    start_nxt    = 1'b0;
    adc_ext_nxt  = adc_ext_r;
    if (adc_en_d_r && !adc_enable) begin
      adc_ext_nxt = 1'b1;
    end
    case (state_r)
      ST_RUN: begin
        if (sleep_req) begin
          state_nxt   = ST_SLEEP;
          mode_nxt    = sleep_select_code;
          mon_off_nxt = off_bit_r && deep_mode(sleep_select_code);
          start_nxt   = adc_enable && !deep_mode(sleep_select_code);
        end
      end
      ST_SLEEP: begin
        if (wake) begin
          state_nxt    = ST_WAKE;
          irq_wake_nxt = !wake_rst;
          // crystal standby keeps the oscillator, so no start-up wait
          if (mode_r[2]) begin
            cnt_nxt = 16'(smcg_pkg::XTAL_WAKE);
          end else if (deep_mode(mode_r)) begin
            cnt_nxt = 16'(STARTUP_CYC);
          end else begin
            cnt_nxt = 16'h0001;
          end
          if (mon_off_r && cnt_nxt < 16'(MON_CYC)) begin
            cnt_nxt = 16'(MON_CYC);
          end
          if (!wake_rst) begin
            cnt_nxt = cnt_nxt + 16'(smcg_pkg::IRQ_HALT);
          end
          mon_off_nxt = 1'b0;
        end
      end
      ST_WAKE: begin
        if (cnt_r <= 16'h0001) begin
          state_nxt = ST_RUN;
        end
      end
      default: state_nxt = ST_RUN;
    endcase
    // a sleep-start conversion consumes the pending extended flag
    if (start_nxt) begin
      adc_ext_nxt = 1'b0;
    end
  end

  // ==========================================
  // clock domain enables
  always_comb begin
    logic slp;
    logic halt;
    logic [2:0] m;
    slp        = (state_nxt == ST_SLEEP);
    halt       = (state_nxt != ST_RUN);
    m          = mode_nxt;
    // core and program store stay halted through the wake delay; other domains restart at once
    ce_nxt     = halt ? 3'h0 : 3'h7;
    io_nxt     = !(slp && stops_io(m));
    adcclk_nxt = !(slp && deep_mode(m));
    osc_nxt    = 1'b1;
    tosc_nxt   = 1'b1;
    if (slp && deep_mode(m)) begin
      osc_nxt  = m[2] || (timer_mode(m) && timer_enable && !timer_async);
      tosc_nxt = timer_mode(m) && timer_enable && timer_async;
    end
    // active and idle see all gates, ADC noise only the ADC gate; deeper modes stop all but a synchronous timer in codes 011 and 111
    pg_nxt = ~peripheral_clock_gate_reg & {smcg_pkg::PG_WIDTH{io_nxt}};
    if (!adcclk_nxt || peripheral_clock_gate_reg[smcg_pkg::PG_ADC]) begin
      pg_nxt[smcg_pkg::PG_ADC] = 1'b0;
    end else begin
      pg_nxt[smcg_pkg::PG_ADC] = 1'b1;
    end
    if (slp && timer_mode(m) && timer_enable && !timer_async) begin
      pg_nxt[smcg_pkg::PG_TIMER_SYNC] = 1'b1;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state_r                <= ST_RUN;
      mode_r                 <= smcg_pkg::SEL_IDLE;
      mon_off_r              <= 1'b0;
      irq_wake_r             <= 1'b0;
      cnt_r                  <= 16'h0000;
      unl_r                  <= 3'h0;
      offcnt_r               <= 3'h0;
      off_bit_r              <= smcg_pkg::CCR_OFF_RESET;
      adc_en_d_r             <= 1'b0;
      adc_ext_r              <= 1'b0;
      start_r                <= 1'b0;
      core_clock_en          <= 1'b1;
      program_store_clock_en <= 1'b1;
      peripheral_io_clock_en <= 1'b1;
      adc_clock_en           <= 1'b1;
      main_osc_en            <= 1'b1;
      timer_osc_en           <= 1'b1;
      periph_clk_en          <= {smcg_pkg::PG_WIDTH{1'b1}};
      supply_drop_monitor_en <= 1'b0;
      monitor_sleep_off      <= 1'b0;
      adc_start              <= 1'b0;
      adc_extended           <= 1'b0;
      asleep                 <= 1'b0;
      irq_resume             <= 1'b0;
    end else if (clk_en) begin
      state_r                <= state_nxt;
      mode_r                 <= mode_nxt;
      mon_off_r              <= mon_off_nxt;
      irq_wake_r             <= irq_wake_nxt;
      cnt_r                  <= cnt_nxt;
      unl_r                  <= unl_nxt;
      offcnt_r               <= offcnt_nxt;
      off_bit_r              <= off_bit_nxt;
      adc_en_d_r             <= adc_enable;
      adc_ext_r              <= adc_ext_nxt;
      start_r                <= start_nxt;
      core_clock_en          <= ce_nxt[0];
      program_store_clock_en <= ce_nxt[1];
      peripheral_io_clock_en <= io_nxt;
      adc_clock_en           <= adcclk_nxt;
      main_osc_en            <= osc_nxt;
      timer_osc_en           <= tosc_nxt;
      periph_clk_en          <= pg_nxt;
      supply_drop_monitor_en <= monitor_fuse_on && !mon_off_nxt;
      monitor_sleep_off      <= off_bit_nxt;
      adc_start              <= start_nxt;
      adc_extended           <= adc_ext_nxt;
      asleep                 <= (state_nxt != ST_RUN);
      irq_resume             <= (state_r == ST_WAKE) && (state_nxt == ST_RUN) && irq_wake_r;
    end
  end
endmodule

// ### tb/smcg_ctrl_asserts.sv
// checker: sleep entry, supply monitor sleep-off sequence, wake timing
// assumes smcg_pkg is compiled first and smcg_ctrl is the bound top
module smcg_ctrl_asserts (
  input wire logic       clock,
  input wire logic       resetn,
  input wire logic       clk_en,
  input wire logic       ccr_wr,
  input wire logic [7:0] ccr_wdata,
  input wire logic       sleep_arm_bit,
  input wire logic [2:0] sleep_select_code,
  input wire logic       sleep_instr,
  input wire logic       monitor_fuse_on,
  input wire logic       adc_enable,
  input wire logic       ext_reset_wake,
  input wire logic       core_clock_en,
  input wire logic       program_store_clock_en,
  input wire logic       peripheral_io_clock_en,
  input wire logic       supply_drop_monitor_en,
  input wire logic       monitor_sleep_off,
  input wire logic       adc_start,
  input wire logic       asleep,
  input wire logic       irq_resume
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking dcb @(posedge clock); endclocking
  default disable iff (!resetn);
  // ==========================================
  // sequences and assertions
  // a request only counts while running; one in the wake delay is not a new entry
  logic take;
  assign take = sleep_instr && sleep_arm_bit && clk_en && !asleep;
  sequence unlock_seq;
    ccr_wr && ccr_wdata[6:5] == 2'h3 ##[1:4] ccr_wr && ccr_wdata[6:5] == 2'h2;
  endsequence
  sequence off_pulse;
    monitor_sleep_off [*3] ##1 !monitor_sleep_off;
  endsequence
  AST_IDLE_ENTRY: assert property (take && sleep_select_code == smcg_pkg::SEL_IDLE |=> asleep
    && !core_clock_en && !program_store_clock_en && peripheral_io_clock_en) else $error("idle entry clocks wrong");
  AST_DEEP_ENTRY: assert property (take && sleep_select_code == smcg_pkg::SEL_PDOWN |=> asleep
    && !core_clock_en && !peripheral_io_clock_en) else $error("power-down entry clocks wrong");
  AST_NO_ARM: assert property (sleep_instr && !sleep_arm_bit && !asleep |=> !asleep)
    else $error("sleep entered without arm bit");
  AST_ADC_START: assert property (take && adc_enable && sleep_select_code == smcg_pkg::SEL_IDLE
    |-> ##[1:2] adc_start) else $error("no conversion start on idle entry");
  AST_MON_OFF: assert property (take && monitor_sleep_off && sleep_select_code == smcg_pkg::SEL_PDOWN
    |-> ##[1:2] !supply_drop_monitor_en) else $error("monitor not off in sleep");
  AST_MON_BACK: assert property ($fell(asleep) |-> supply_drop_monitor_en == monitor_fuse_on)
    else $error("monitor not restored on wake");
  AST_IRQ_RESUME: assert property (irq_resume |-> !asleep && core_clock_en)
    else $error("resume pulse outside wake");
  AST_UNLOCK: assert property (unlock_seq |-> ##[1:5] monitor_sleep_off)
    else $error("sleep-off not set after unlock");
  AST_OFF_PULSE: assert property ($rose(monitor_sleep_off) |-> off_pulse)
    else $error("sleep-off not held three cycles");
  AST_STBY_WAKE: assert property (asleep && $rose(ext_reset_wake) && sleep_select_code == smcg_pkg::SEL_STBY
    |-> asleep [*7] ##1 !asleep) else $error("standby wake time wrong");
  AST_HALT_IN_WAKE: assert property (asleep |-> !core_clock_en && !program_store_clock_en)
    else $error("core clock running while asleep or waking");
endmodule
bind smcg_ctrl smcg_ctrl_asserts chk_u (.clock, .resetn, .clk_en, .ccr_wr, .ccr_wdata, .sleep_arm_bit,
  .sleep_select_code, .sleep_instr, .monitor_fuse_on, .adc_enable, .ext_reset_wake, .core_clock_en,
  .program_store_clock_en, .peripheral_io_clock_en, .supply_drop_monitor_en, .monitor_sleep_off,
  .adc_start, .asleep, .irq_resume);

// ### tb/smcg_core_model.sv
// core model: control register writes and the sleep instruction pulse
// assumes the controller samples on the rising edge; drives on the falling one
module smcg_core_model (
  input wire logic  clock,
  output logic       ccr_wr,
  output logic [7:0] ccr_wdata
  ,output logic      sleep_instr
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    ccr_wr = 1'h0;
    ccr_wdata = 8'h00;
    sleep_instr = 1'h0;
  end
  // ==========================================
  // access tasks
  task automatic write_ccr(input logic [7:0] d);
    @(negedge clock);
    ccr_wr = 1'h1;
    ccr_wdata = d;
    @(negedge clock);
    ccr_wr = 1'h0;
    // data is meaningless without the strobe; show garbage, not the last value
    ccr_wdata = ~d;
  endtask
  task automatic unlock_off();
    write_ccr(8'h60);
    write_ccr(8'h40);
  endtask
  task automatic sleep_now();
    @(negedge clock);
    sleep_instr = 1'h1;
    @(negedge clock);
    sleep_instr = 1'h0;
  endtask
endmodule

// ### tb/tb_top.sv
// testbench for the sleep-mode and clock-gating controller
// assumes smcg_pkg, the checker bind and the core model are compiled first
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clock, resetn, ccr_wr, sleep_instr, sleep_arm_bit, xtal_selected, adc_enable, global_irq_en;
  logic        core_clock_en, program_store_clock_en, peripheral_io_clock_en, adc_clock_en, main_osc_en;
  logic        timer_osc_en, supply_drop_monitor_en, monitor_sleep_off, adc_extended, asleep, irq_resume;
  logic        woke, irq_seen;
  logic        clk_en, monitor_fuse_on, timer_async, timer_enable, adc_start;
  logic [2:0]  sleep_select_code;
  logic [7:0]  ccr_wdata, peripheral_clock_gate_reg, periph_clk_en;
  logic [18:0] wk;
  int          fail_count, n_compared, n;
  localparam logic [2:0]  MODE[6]  = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h6, 3'h7};
  localparam logic [3:0]  CLKS[6]  = '{4'hF, 4'h7, 4'h0, 4'h1, 4'h2, 4'h3};
  localparam logic [18:0] WAKES[6] = '{19'h7_FFFF, 19'h7_E1FF, 19'h0_1C57, 19'h6_1C57, 19'h0_1C57, 19'h6_1C57};
  localparam int          DLY[6]   = '{1, 1, 8, 8, 6, 6};
  // short start-up and monitor counts keep the run brief
  smcg_ctrl #(.STARTUP_CYC(8), .MON_CYC(12)) dut_u (.clock, .resetn, .clk_en, .ccr_wr, .ccr_wdata,
    .sleep_arm_bit, .sleep_select_code, .sleep_instr, .xtal_selected, .monitor_fuse_on, .adc_enable,
    .timer_async, .timer_enable, .async_timer_irq_mask(2'h3), .global_irq_en,
    .async_timer_events(wk[18:17]), .ext_reset_wake(wk[0]), .wdt_reset_wake(wk[1]), .mon_reset_wake(wk[2]),
    .wdt_irq_wake(wk[3]), .twi_addr_match(wk[4]), .twi_irq(wk[5]), .pin_change_irq(wk[6]),
    .adc_done_irq(wk[7]), .store_ready_irq(wk[8]), .other_irq(wk[9]), .low_ext_irq_lines(wk[12:10]),
    .high_ext_irq_lines(wk[16:13]), .peripheral_clock_gate_reg, .core_clock_en, .program_store_clock_en,
    .peripheral_io_clock_en, .adc_clock_en, .main_osc_en, .timer_osc_en, .periph_clk_en,
    .supply_drop_monitor_en, .monitor_sleep_off, .adc_start, .adc_extended, .asleep, .irq_resume);
  smcg_core_model core_u (.clock, .ccr_wr, .ccr_wdata, .sleep_instr);
  // ==========================================
  // tasks
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic enter(input logic [2:0] c);
    @(negedge clock);
    sleep_select_code = c;
    sleep_arm_bit = 1'h1;
    core_u.sleep_now();
  endtask
  task automatic try_wake(input int b);
    @(negedge clock);
    wk[b] = 1'h1;
    n = 0;
    while (asleep === 1'h1 && n < 40) begin
      @(posedge clock);
      #1;
      n++;
      if (irq_resume === 1'h1) irq_seen = 1'h1;
    end
    woke = (asleep === 1'h0);
    @(negedge clock);
    wk[b] = 1'h0;
  endtask
  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // ==========================================
  // clock, watchdog and test sequence
  initial begin
    clock = 1'h0;
    forever #25 clock = ~clock;
  end
  initial begin
    #(60000 * smcg_pkg::CLK_PERIOD_NS);
    fail_count++;
    print_verdict();
  end
  initial begin
    {resetn, sleep_arm_bit, sleep_select_code, peripheral_clock_gate_reg, wk, irq_seen} = '0;
    {xtal_selected, adc_enable, global_irq_en, clk_en, monitor_fuse_on, timer_async, timer_enable} = 7'h7F;
    repeat (2) @(negedge clock);
    check("gates in reset", 8'hFF, periph_clk_en);
    resetn = 1'h1;
    repeat (2) @(negedge clock);
    check("sleep-off after reset", 0, monitor_sleep_off);
    for (int m = 0; m < 6; m++) begin
      for (int b = 0; b < 19; b++) begin
        enter(MODE[m]);
        if (b == 0) check("clocks", {2'h0, CLKS[m]}, {core_clock_en, program_store_clock_en,
          peripheral_io_clock_en, adc_clock_en, main_osc_en, timer_osc_en});
        if (b == 0) check("conversion start", {31'h0, m < 2}, adc_start);
        try_wake(b);
        check("wake source", {31'h0, WAKES[m][b]}, woke);
        if (b == 0) check("wake time", 1, n >= DLY[m] && n <= DLY[m] + 1);
        if (!woke) try_wake(0);
      end
      $display("mode %0d test done", m);
    end
    for (int k = 0; k < 4; k++) begin
      @(negedge clock);
      sleep_arm_bit = (k != 0);
      xtal_selected = (k != 3);
      sleep_select_code = 3'h3 + k[2:0];
      core_u.sleep_now();
      check("refused sleep", 0, asleep);
    end
    xtal_selected = 1'h1;
    core_u.write_ccr(8'h40);
    repeat (4) @(negedge clock);
    check("sleep-off without unlock", 0, monitor_sleep_off);
    sleep_select_code = smcg_pkg::SEL_PDOWN;
    core_u.unlock_off();
    n = 0;
    while (monitor_sleep_off !== 1'h1 && n < 8) begin
      @(negedge clock);
      n++;
    end
    core_u.sleep_now();
    @(negedge clock);
    check("monitor in sleep", 0, supply_drop_monitor_en);
    irq_seen = 1'h0;
    try_wake(10);
    check("slow wake", 1, woke && n >= 16 && n <= 17);
    check("resume pulse", 1, irq_seen);
    check("monitor after wake", 1, supply_drop_monitor_en);
    $display("monitor test done");
    peripheral_clock_gate_reg = 8'h81;
    enter(smcg_pkg::SEL_IDLE);
    check("gated in idle", 8'h7E, periph_clk_en);
    irq_seen = 1'h0;
    try_wake(0);
    check("no resume on reset wake", 0, irq_seen);
    peripheral_clock_gate_reg = 8'h00;
    repeat (2) @(negedge clock);
    check("ungated", 8'hFF, periph_clk_en);
    global_irq_en = 1'h0;
    enter(smcg_pkg::SEL_PSAVE);
    try_wake(17);
    check("timer wake, irqs off", 0, woke);
    try_wake(0);
    global_irq_en = 1'h1;
    timer_enable = 1'h0;
    enter(smcg_pkg::SEL_PSAVE);
    try_wake(18);
    check("timer wake, timer off", 0, woke);
    try_wake(0);
    timer_enable = 1'h1;
    timer_async = 1'h0;
    enter(smcg_pkg::SEL_PSAVE);
    check("sync timer clocks", 3'h5, {main_osc_en, timer_osc_en, periph_clk_en[6]});
    try_wake(18);
    check("sync timer wake", 1, woke);
    timer_async = 1'h1;
    clk_en = 1'h0;
    core_u.sleep_now();
    check("frozen sleep", 0, asleep);
    clk_en = 1'h1;
    monitor_fuse_on = 1'h0;
    @(negedge clock);
    check("monitor fuse off", 0, supply_drop_monitor_en);
    monitor_fuse_on = 1'h1;
    adc_enable = 1'h0;
    repeat (2) @(negedge clock);
    adc_enable = 1'h1;
    @(negedge clock);
    check("extended pending", 1, adc_extended);
    enter(smcg_pkg::SEL_IDLE);
    try_wake(0);
    check("extended cleared", 0, adc_extended);
    $display("feature test done");
    print_verdict();
  end
endmodule
